/* hdl/driver_ctrl.v */
// Serial control interface and output logic of the six-output driver.
`include "driver_ctrl_regs.vh"
module driver_ctrl (
    // Clock and reset
    input wire ref_clk,
    input wire rst,
    // Serial link pins
    input wire select_n,
    input wire serial_clk,
    input wire serial_in,
    output reg serial_out,
    output reg serial_out_en,
    // PWM input pin
    input wire pwm_in,
    // Analog status inputs; the six-bit buses have one bit per output in drive order
    input wire temp_warn_in,
    input wire [5:0] open_load_in,
    input wire [5:0] fault_off_in,
    input wire undervoltage_in,
    // Driver and mode outputs
    output reg [5:0] drive_out,
    output reg open_load_enable,
    output reg overcurrent_enable,
    output reg standby
);
    // ****************************************************************
    // Pin synchronisers
    // ****************************************************************
    wire sel_lvl;
    wire sel_rise;
    wire sel_fall;
    wire sck_rise;
    wire sck_fall;
    wire sdi_lvl;
    wire pwm_lvl;
    wire temp_lvl;
    wire uv_lvl;

    // Select rests high, so its synchroniser resets high to avoid a false rise.
    edge_sync #(.IDLE(1'b1)) sync_sel (.ref_clk(ref_clk), .rst(rst), .async_in(select_n),
        .level(sel_lvl), .rise(sel_rise), .fall(sel_fall));
    edge_sync sync_sck (.ref_clk(ref_clk), .rst(rst), .async_in(serial_clk),
        .level(), .rise(sck_rise), .fall(sck_fall));
    edge_sync sync_sdi (.ref_clk(ref_clk), .rst(rst), .async_in(serial_in),
        .level(sdi_lvl), .rise(), .fall());
    edge_sync sync_pwm (.ref_clk(ref_clk), .rst(rst), .async_in(pwm_in),
        .level(pwm_lvl), .rise(), .fall());
    edge_sync sync_tmp (.ref_clk(ref_clk), .rst(rst), .async_in(temp_warn_in),
        .level(temp_lvl), .rise(), .fall());
    edge_sync sync_uv (.ref_clk(ref_clk), .rst(rst), .async_in(undervoltage_in),
        .level(uv_lvl), .rise(), .fall());

    // Six-bit buses pass the same two flip-flops.
    reg [5:0] ol_meta;
    reg [5:0] ol_lvl;
    reg [5:0] flt_meta;
    reg [5:0] flt_lvl;

    // Synchronise the per-output status buses.
    always @(posedge ref_clk) begin
        if (rst) begin
            ol_meta <= 6'h00;
            ol_lvl <= 6'h00;
            flt_meta <= 6'h00;
            flt_lvl <= 6'h00;
        end else begin
            ol_meta <= open_load_in;
            ol_lvl <= ol_meta;
            flt_meta <= fault_off_in;
            flt_lvl <= flt_meta;
        end
    end

    // ****************************************************************
    // Registers
    // ****************************************************************
    reg [15:0] output_control_word;
    reg [15:0] shift_in;
    reg [15:0] shift_out;
    reg supply_fail_flag;
    reg overload_flag;
    reg [4:0] bit_count;

    wire active = ~sel_lvl;
    wire [5:0] drive_bits = output_control_word[`CTL_DRIVE_LSB +: 6];
    wire [5:0] pwm_sel = output_control_word[`CTL_PWM_LSB +: 6];
    wire run_enable = output_control_word[`CTL_RUN_ENABLE];
    wire status_clear_now = sel_rise & (bit_count == 5'd16) & shift_in[`CTL_STATUS_CLEAR];

    // Per-output state for status bits 1 to 6: open-load result or on state.
    wire [5:0] out_state = output_control_word[`CTL_OPEN_LOAD_N] ? drive_out : (ol_lvl & ~drive_bits);

    // Status word snapshot taken as the frame opens.
    wire [15:0] status_word = {supply_fail_flag, ~run_enable, overload_flag, 6'h00,
        out_state, temp_lvl};

    // Receive shift register; word taken only after a full frame.
    always @(posedge ref_clk) begin
        if (rst) begin
            shift_in <= 16'h0000;
            bit_count <= 5'd0;
            output_control_word <= `CTL_RESET_VALUE;
        end else if (sel_fall) begin
            bit_count <= 5'd0;
        end else if (active && sck_fall) begin
            shift_in <= {sdi_lvl, shift_in[15:1]};
            if (bit_count != 5'd16) begin
                bit_count <= bit_count + 5'd1;
            end
        end else if (sel_rise && bit_count == 5'd16) begin
            output_control_word <= shift_in;
        end
    end

    // Transmit side: load on select fall, advance on rising clock edges.
    always @(posedge ref_clk) begin
        if (rst) begin
            shift_out <= 16'h0000;
            serial_out <= 1'b0;
            serial_out_en <= 1'b0;
        end else if (sel_fall) begin
            shift_out <= {1'b0, status_word[15:1]};
            serial_out <= status_word[`STS_TEMP_PREWARN];
            serial_out_en <= 1'b1;
        end else if (sel_rise) begin
            serial_out_en <= 1'b0;
        end else if (active && sck_rise) begin
            serial_out <= shift_out[0];
            shift_out <= {1'b0, shift_out[15:1]};
        end
    end

    // Sticky diagnostic flags; a new event wins over a clear.
    always @(posedge ref_clk) begin
        if (rst) begin
            supply_fail_flag <= 1'b0;
            overload_flag <= 1'b0;
        end else begin
            if (uv_lvl) begin
                supply_fail_flag <= 1'b1;
            end else if (status_clear_now) begin
                supply_fail_flag <= 1'b0;
            end
            if (|flt_lvl) begin
                overload_flag <= 1'b1;
            end else if (status_clear_now) begin
                overload_flag <= 1'b0;
            end
        end
    end

    // ****************************************************************
    // Output logic
    // ****************************************************************
    reg [5:0] next_drive;
    integer i;

    // Combine switch, PWM gating, faults, supply and half-bridge interlock.
    always @* begin
        next_drive = drive_bits;
        for (i = 0; i < 6; i = i + 1) begin
            if (pwm_sel[i]) begin
                next_drive[i] = drive_bits[i] & pwm_lvl;
            end
        end
        next_drive = next_drive & ~flt_lvl;
        for (i = 0; i < 3; i = i + 1) begin
            if (next_drive[2 * i] && next_drive[2 * i + 1]) begin
                next_drive[2 * i] = 1'b0;
                next_drive[2 * i + 1] = 1'b0;
            end
        end
        if (uv_lvl || !run_enable) begin
            next_drive = 6'h00;
        end
    end

    // Register the drive and mode outputs.
    always @(posedge ref_clk) begin
        if (rst) begin
            drive_out <= 6'h00;
            open_load_enable <= 1'b0;
            overcurrent_enable <= 1'b1;
            standby <= 1'b0;
        end else begin
            drive_out <= next_drive;
            open_load_enable <= ~output_control_word[`CTL_OPEN_LOAD_N];
            overcurrent_enable <= output_control_word[`CTL_OC_SHUTDOWN];
            standby <= ~run_enable;
        end
    end
endmodule // driver_ctrl

/* hdl/driver_ctrl_regs.vh */
// Constants for the six-output driver serial control block.
// Functional notes
// - Select low starts transfer; high ignores link.
// - Serial input sampled on falling clock edge.
// - Control register loads on select rising edge.
// - Serial out tristate while select high.
// - Serial out changes on rising clock edge.
// - Status word shifted out LSB first.
// - Status clear bit clears supply and overload.
// - Bits 1 to 6 switch the six outputs.
// - Bits 7 to 12 select PWM gating.
// - Gated outputs follow the PWM input only while their switch bit is on.
// - Bit 13 low enables open-load detection.
// - Bit 14 high enables overcurrent shutdown.
// - Bit 15 low means standby; link keeps working.
// - Status word layout with unused bits 7-12.
// - Reset: run, overcurrent, open-load bits high.
// - Undervoltage sets supply flag, disables outputs.
// - Fault switch-off sets the overload flag.
`ifndef DRIVER_CTRL_REGS_VH
`define DRIVER_CTRL_REGS_VH

// ****************************************************************
// Word layout
// ****************************************************************
`define WORD_BITS 16
`define CTL_STATUS_CLEAR 0
`define CTL_DRIVE_LSB 1
`define CTL_PWM_LSB 7
`define CTL_OPEN_LOAD_N 13
`define CTL_OC_SHUTDOWN 14
`define CTL_RUN_ENABLE 15
`define CTL_RESET_VALUE 16'he000
`define STS_TEMP_PREWARN 0
`define STS_OUT_LSB 1
`define STS_OVERLOAD 13
`define STS_STANDBY 14
`define STS_SUPPLY_FAIL 15

`endif

/* hdl/edge_sync.v */
// Two-flop synchroniser with edge detection for one input.
module edge_sync #(
    // Level the pin rests at while idle; reset loads it so no false edge follows reset.
    parameter IDLE = 1'b0
) (
    // Clock and reset
    input wire ref_clk,
    input wire rst,
    // Asynchronous input
    input wire async_in,
    // Synchronised level and one-cycle edge pulses
    output reg level,
    output wire rise,
    output wire fall
);
    reg meta;
    reg prev;

    // Synchronise and keep the previous level for edge detection.
    always @(posedge ref_clk) begin
        if (rst) begin
            meta <= IDLE;
            level <= IDLE;
            prev <= IDLE;
        end else begin
            meta <= async_in;
            level <= meta;
            prev <= level;
        end
    end

    assign rise = level & ~prev;
    assign fall = ~level & prev;
endmodule // edge_sync

/* verification/driver_ctrl_checker.sv */
// Concurrent checks on the ports of the driver control block.
module driver_ctrl_checker (
    // Clock and reset
    input wire ref_clk,
    input wire rst,
    // Watched pins
    input wire select_n,
    input wire serial_clk,
    input wire serial_out,
    input wire serial_out_en,
    input wire pwm_in,
    input wire [5:0] fault_off_in,
    input wire undervoltage_in,
    input wire [5:0] drive_out,
    input wire open_load_enable,
    input wire overcurrent_enable,
    input wire standby
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (rst);
    logic clk_q;
    logic [3:0] since_rise;
    // Counts cycles since the sampled link clock last rose, saturating.
    always @(posedge ref_clk) begin
        clk_q <= serial_clk;
        if (rst) since_rise <= 4'hf;
        else if (serial_clk && !clk_q) since_rise <= 4'h0;
        else if (since_rise != 4'hf) since_rise <= since_rise + 4'h1;
    end
    sequence frame_start_s;
        $fell(select_n);
    endsequence
    sequence quiet_s;
        (!select_n && $stable(pwm_in) && $stable(fault_off_in) && $stable(undervoltage_in)) [*8];
    endsequence
    reset_values_a: assert property ($fell(rst) |-> drive_out == 6'h00 && overcurrent_enable
        && !standby && !open_load_enable) else $error("reset values wrong");
    tristate_idle_a: assert property (select_n [*8] |-> !serial_out_en)
        else $error("serial out driven while deselected");
    enable_on_select_a: assert property (frame_start_s |-> ##[2:6] serial_out_en)
        else $error("serial out not enabled");
    out_hold_a: assert property (serial_out_en && $past(serial_out_en) && $changed(serial_out)
        |-> since_rise >= 4'h1 && since_rise <= 4'h6) else $error("serial out moved off clock rise");
    load_on_rise_a: assert property (quiet_s |-> $stable(drive_out))
        else $error("outputs moved inside frame");
    half_bridge_a: assert property ((drive_out & {drive_out[4], drive_out[5], drive_out[2],
        drive_out[3], drive_out[0], drive_out[1]}) == 6'h00) else $error("half bridge conflict");
    standby_off_a: assert property (standby |-> drive_out == 6'h00)
        else $error("output on in standby");
    undervolt_off_a: assert property (undervoltage_in [*6] |-> drive_out == 6'h00)
        else $error("output on in undervoltage");
    fault_off_a: assert property ($stable(fault_off_in) [*6] |-> (drive_out & fault_off_in) == 6'h00)
        else $error("faulted output on");
endmodule // driver_ctrl_checker
bind driver_ctrl driver_ctrl_checker i_driver_ctrl_checker (.*);

/* verification/driver_ctrl_test.sv */
// Self-checking testbench of the six-output driver serial control block.
module driver_ctrl_test;
    timeunit 1ns;
    timeprecision 100ps;
    logic ref_clk, rst, pwm_in, temp_warn_in, undervoltage_in;
    logic [5:0] open_load_in, fault_off_in;
    logic [15:0] r;
    wire select_n, serial_clk, serial_in, serial_out, serial_out_en, data_line;
    wire open_load_enable, overcurrent_enable, standby;
    wire [5:0] drive_out;
    int num_errors = 0, num_checks = 0, cycles = 0;
    // The return line floats while the block does not drive it.
    assign data_line = serial_out_en ? serial_out : 1'bz;
    driver_ctrl i_driver_ctrl (.*);
    link_master i_link_master (.*);
    // Clock at 125 MHz.
    initial begin
        ref_clk = 1'b0;
        forever #4 ref_clk = ~ref_clk;
    end
    // Cuts a hung run short.
    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 20000) begin
            num_errors++;
            tally_and_finish;
        end
    end
    task check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        num_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task cyc(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask
    task frame(input logic [15:0] w, input int n);
        i_link_master.xfer(w, n, r);
        cyc(1);
    endtask
    task tally_and_finish;
        $display("Counts: %0d checks, %0d mismatches", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    task t_reset;
        temp_warn_in = 1'b1;
        cyc(4);
        frame(16'he000, 16);
        check("status", r, 16'h0001);
        check("modes", {drive_out, open_load_enable, overcurrent_enable, standby}, {6'h00, 3'b010});
        temp_warn_in = 1'b0;
        $display("Test reset done");
    endtask
    task t_drive;
        frame(16'he036, 16);
        check("drive", drive_out, 6'h18);
        frame(16'he000, 16);
        check("status", r, 16'h0030);
        $display("Test drive done");
    endtask
    task t_pwm;
        for (int k = 0; k < 6; k++) begin
            pwm_in = 1'b0;
            frame(16'he000 | (16'h0082 << k), 16);
            check("pwm low", drive_out, 6'h00);
            pwm_in = 1'b1;
            cyc(6);
            check("pwm high", drive_out, 6'h01 << k);
        end
        frame(16'he100, 16);
        check("pwm no switch", drive_out, 6'h00);
        pwm_in = 1'b0;
        $display("Test pwm done");
    endtask
    task t_modes;
        frame(16'h0002, 16);
        check("modes", {drive_out, open_load_enable, overcurrent_enable, standby}, {6'h00, 3'b101});
        open_load_in = 6'h03;
        frame(16'he002, 16);
        check("status", r, 16'h4004);
        check("drive", drive_out, 6'h01);
        frame(16'he002, 16);
        check("status on", r, 16'h0002);
        open_load_in = 6'h00;
        $display("Test modes done");
    endtask
    task t_flags;
        undervoltage_in = 1'b1;
        cyc(8);
        check("uv drive", drive_out, 6'h00);
        undervoltage_in = 1'b0;
        cyc(8);
        check("uv back", drive_out, 6'h01);
        fault_off_in = 6'h01;
        cyc(8);
        check("fault drive", drive_out, 6'h00);
        fault_off_in = 6'h00;
        cyc(8);
        frame(16'he003, 16);
        check("flags", r, 16'ha002);
        frame(16'he002, 16);
        check("cleared", r, 16'h0002);
        frame(16'he000, 8);
        check("short status", r, 16'h0002);
        check("short drive", drive_out, 6'h01);
        $display("Test flags done");
    endtask
    // Main sequence.
    initial begin
        rst = 1'b1;
        pwm_in = 1'b0;
        temp_warn_in = 1'b0;
        undervoltage_in = 1'b0;
        open_load_in = 6'h00;
        fault_off_in = 6'h00;
        cyc(5);
        rst = 1'b0;
        cyc(6);
        t_reset;
        t_drive;
        t_pwm;
        t_modes;
        t_flags;
        tally_and_finish;
    end
endmodule // driver_ctrl_test

/* verification/link_master.sv */
// Serial bus master model that drives the select, clock and data pins of the block.
module link_master (
    // Link pins
    output logic select_n,
    output logic serial_clk,
    output logic serial_in,
    input wire logic data_line
);
    timeunit 1ns;
    timeprecision 100ps;
    // Idle levels: select pulled up, clock and data pulled down, clock stands still.
    initial begin
        select_n = 1'b1;
        serial_clk = 1'b0;
        serial_in = 1'b0;
    end
    // One frame of n bits, LSB first, 80 ns per bit; returned bits are taken before each rise.
    task xfer(input logic [15:0] w, input int n, output logic [15:0] r);
        r = 16'h0000;
        select_n = 1'b0;
        #80;
        for (int i = 0; i < n; i++) begin
            #20 serial_in = w[i];
            #20 r[i] = data_line;
            serial_clk = 1'b1;
            #40 serial_clk = 1'b0;
        end
        #40 select_n = 1'b1;
        serial_in = 1'b0;
        #200;
    endtask
endmodule // link_master
